// ===== design/trail_trace_receive_path.sv
`timescale 1ns/1ps
`include "trace_rx_consts.svh"

module trail_trace_receive_path
  import trace_rx_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        trace_serial_bit,
  input  wire logic        trace_bit_valid,
  input  wire logic        line_los,
  input  wire logic        line_lof,
  input  wire logic        line_ais,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             trace_change,
  output logic             trace_idle,
  output logic             trace_unstable,
  output logic             trace_mismatch
);

  rx_state_t s;
  rx_state_t next_s;

  logic       cur_we;
  logic       acc_we;
  logic       exp_we;
  logic [3:0] exp_idx;
  logic [7:0] exp_byte;
  logic [7:0] mem_rd_data;
  trace_id_t  cur_id;
  trace_id_t  acc_id;
  trace_id_t  exp_id;
  trace_id_t  new_id;

  function automatic logic [7:0] rev8(input logic [7:0] b);
    logic [7:0] r;
    for (int i = 0; i < 8; i++) begin
      r[i] = b[7 - i];
    end
    return r;
  endfunction : rev8

  // Clears the alignment bit, which sits at bit 7 or bit 0 once stored.
  function automatic trace_id_t mask_id(input trace_id_t id,
                                        input logic      reorder);
    trace_id_t m;
    m = id;
    for (int i = 0; i < 16; i++) begin
      if (reorder) begin
        m[i][0] = 1'b0;
      end else begin
        m[i][7] = 1'b0;
      end
    end
    return m;
  endfunction : mask_id

  function automatic logic is_store(input logic [7:0] addr);
    return addr[7:2] >= `TRX_STORE_WBASE;
  endfunction : is_store

  function automatic logic [5:0] store_idx(input logic [7:0] addr);
    return addr[7:2] - `TRX_STORE_WBASE;
  endfunction : store_idx

  trace_store u_store (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .cur_we   (cur_we),
    .cur_data (new_id),
    .acc_we   (acc_we),
    .acc_data (new_id),
    .exp_we   (exp_we),
    .exp_idx  (exp_idx),
    .exp_byte (exp_byte),
    .rd_addr  (store_idx(s.araddr)),
    .rd_data  (mem_rd_data),
    .cur_id   (cur_id),
    .acc_id   (acc_id),
    .exp_id   (exp_id)
  );

  always_comb begin
    logic       do_write;
    logic [5:0] widx;
    logic       bit_in;
    logic       byte_done;
    logic [7:0] rx_byte;
    logic [7:0] st_byte;
    logic       place;
    logic [3:0] place_idx;
    logic       id_done;
    logic       id_zero;
    logic       id_same;
    logic       id_diff;
    logic [2:0] rpt;
    logic [3:0] unst;
    logic       reorder;
    logic       cmp_on;
    logic [7:0] stat;

    next_s    = s;
    do_write  = 1'b0;
    widx      = store_idx(s.awaddr);
    exp_we    = 1'b0;
    exp_idx   = widx[3:0];
    exp_byte  = s.wdata[7:0];
    cur_we    = 1'b0;
    acc_we    = 1'b0;
    byte_done = 1'b0;
    place     = 1'b0;
    place_idx = s.byte_idx;
    id_done   = 1'b0;
    id_same   = 1'b0;
    id_diff   = 1'b0;
    rpt       = s.rpt_cnt;
    unst      = s.unst_cnt;
    reorder   = s.ctrl[`TRX_CTRL_REORDER];
    cmp_on    = s.ctrl[`TRX_CTRL_CMP] & s.ctrl[`TRX_CTRL_ALIGN];
    bit_in    = 1'b0;
    rx_byte   = 8'h00;
    st_byte   = 8'h00;
    id_zero   = 1'b0;
    stat      = {2'b00, s.aligned, s.acc_valid, s.mismatch, s.unstable,
                 s.idle, s.change};

    // Write channel: address and data are held independently.
    if (s_axi_awvalid && s.awready) begin
      next_s.aw_held = 1'b1;
      next_s.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s.wready) begin
      next_s.w_held = 1'b1;
      next_s.wdata  = s_axi_wdata;
      next_s.wstrb  = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    if (s.aw_held && s.w_held && !s.bvalid) begin
      do_write       = 1'b1;
      next_s.aw_held = 1'b0;
      next_s.w_held  = 1'b0;
      next_s.bvalid  = 1'b1;
      next_s.bresp   = `TRX_RESP_OKAY;
    end
    if (do_write) begin
      if (s.awaddr[7:2] == `TRX_CTRL_OFS >> 2) begin
        if (s.wstrb[0]) begin
          next_s.ctrl = s.wdata[3:0];
        end
      end else if (s.awaddr[7:2] == `TRX_STAT_OFS >> 2) begin
        if (s.wstrb[0] && s.wdata[`TRX_STAT_CHANGE]) begin
          next_s.change = 1'b0;
        end
      end else if (is_store(s.awaddr)) begin
        exp_we = s.wstrb[0] && (widx >= `TRX_EXP_IDX);
      end else begin
        next_s.bresp = `TRX_RESP_SLVERR;
      end
    end
    next_s.awready = !next_s.aw_held && !next_s.bvalid;
    next_s.wready  = !next_s.w_held && !next_s.bvalid;

    // Read channel: every read, not only storage reads, takes one extra cycle through the memory.
    unique case (s.rd_st)
      RD_IDLE: begin
        if (s_axi_arvalid && s.arready) begin
          next_s.araddr = s_axi_araddr;
          next_s.rd_st  = RD_ADDR;
        end
      end
      RD_ADDR: begin
        next_s.rd_st = RD_DATA;
      end
      RD_DATA: begin
        next_s.rresp = `TRX_RESP_OKAY;
        next_s.rdata = 32'h0000_0000;
        if (s.araddr[7:2] == `TRX_CTRL_OFS >> 2) begin
          next_s.rdata = {28'h000_0000, s.ctrl};
        end else if (s.araddr[7:2] == `TRX_STAT_OFS >> 2) begin
          next_s.rdata = {24'h00_0000, stat};
        end else if (is_store(s.araddr)) begin
          next_s.rdata = {24'h00_0000, mem_rd_data};
        end else begin
          next_s.rresp = `TRX_RESP_SLVERR;
        end
        next_s.rvalid = 1'b1;
        next_s.rd_st  = RD_RESP;
      end
      RD_RESP: begin
        if (s_axi_rready) begin
          next_s.rvalid = 1'b0;
          next_s.rd_st  = RD_IDLE;
        end
      end
    endcase
    next_s.arready = (next_s.rd_st == RD_IDLE);

    // Line side: optional inversion, then defects force ones.
    bit_in = (line_los || line_lof || line_ais) ? 1'b1 :
             (trace_serial_bit ^ s.ctrl[`TRX_CTRL_INV]);
    rx_byte = {s.shift, bit_in};
    if (trace_bit_valid) begin
      next_s.shift = {s.shift[5:0], bit_in};
      if (s.bit_cnt == `TRX_LAST_BIT) begin
        byte_done      = 1'b1;
        next_s.bit_cnt = 3'd0;
      end else begin
        next_s.bit_cnt = s.bit_cnt + 3'd1;
      end
    end
    st_byte = reorder ? rev8(rx_byte) : rx_byte;

    if (byte_done) begin
      if (!s.ctrl[`TRX_CTRL_ALIGN]) begin
        place           = 1'b1;
        id_done         = (s.byte_idx == `TRX_LAST_BYTE);
        next_s.byte_idx = s.byte_idx + 4'd1;
        next_s.align_st = ALIGN_HUNT;
        next_s.aligned  = 1'b0;
      end else if (rx_byte[7]) begin
        // A start bit always restarts the identifier at location zero.
        place           = 1'b1;
        place_idx       = 4'd0;
        next_s.byte_idx = 4'd1;
        next_s.align_st = ALIGN_COLLECT;
        if (s.align_st == ALIGN_COLLECT) begin
          next_s.aligned = 1'b0;
        end
      end else if (s.align_st == ALIGN_COLLECT) begin
        place   = 1'b1;
        id_done = (s.byte_idx == `TRX_LAST_BYTE);
        if (id_done) begin
          next_s.byte_idx = 4'd0;
          next_s.align_st = ALIGN_HUNT;
          next_s.aligned  = 1'b1;
        end else begin
          next_s.byte_idx = s.byte_idx + 4'd1;
        end
      end
    end

    new_id = s.stage;
    if (place) begin
      new_id[place_idx] = st_byte;
    end
    next_s.stage = new_id;
    id_zero = (mask_id(new_id, reorder) == '0);

    if (id_done) begin
      cur_we  = 1'b1;
      id_same = (new_id == cur_id);
      id_diff = (new_id != cur_id) && (new_id != acc_id);
      if (!id_same) begin
        rpt = 3'd1;
      end else if (s.rpt_cnt != `TRX_RPT_LIMIT) begin
        rpt = s.rpt_cnt + 3'd1;
      end
      if (!id_diff) begin
        unst = 4'd0;
      end else if (s.unst_cnt != `TRX_UNST_LIMIT) begin
        unst = s.unst_cnt + 4'd1;
      end
      next_s.rpt_cnt  = rpt;
      next_s.unst_cnt = unst;
      if (rpt == `TRX_RPT_LIMIT && !id_zero && new_id != acc_id) begin
        acc_we           = 1'b1;
        next_s.acc_valid = 1'b1;
        next_s.change    = 1'b1;
      end
      if (rpt == `TRX_RPT_LIMIT) begin
        next_s.idle     = id_zero;
        next_s.unstable = 1'b0;
      end
      if (unst == `TRX_UNST_LIMIT) begin
        next_s.unstable = 1'b1;
        next_s.idle     = 1'b0;
      end
    end

    next_s.mismatch = cmp_on && s.acc_valid &&
      (mask_id(acc_id, reorder) != mask_id(exp_id, reorder));
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign s_axi_awready  = s.awready;
  assign s_axi_wready   = s.wready;
  assign s_axi_bresp    = s.bresp;
  assign s_axi_bvalid   = s.bvalid;
  assign s_axi_arready  = s.arready;
  assign s_axi_rdata    = s.rdata;
  assign s_axi_rresp    = s.rresp;
  assign s_axi_rvalid   = s.rvalid;
  assign trace_change   = s.change;
  assign trace_idle     = s.idle;
  assign trace_unstable = s.unstable;
  assign trace_mismatch = s.mismatch;

endmodule : trail_trace_receive_path

// ===== pkg/trace_rx_consts.svh
`ifndef TRACE_RX_CONSTS_SVH
`define TRACE_RX_CONSTS_SVH

`define TRX_CTRL_OFS     8'h00
`define TRX_STAT_OFS     8'h04
`define TRX_STORE_BASE   8'h40
`define TRX_STORE_WBASE  6'h10

`define TRX_CUR_IDX      6'd0
`define TRX_ACC_IDX      6'd16
`define TRX_EXP_IDX      6'd32
`define TRX_STORE_BYTES  48

`define TRX_CTRL_INV     0
`define TRX_CTRL_ALIGN   1
`define TRX_CTRL_CMP     2
`define TRX_CTRL_REORDER 3
`define TRX_CTRL_RESET   4'h0

`define TRX_STAT_CHANGE  0
`define TRX_STAT_IDLE    1
`define TRX_STAT_UNSTAB  2
`define TRX_STAT_MISM    3
`define TRX_STAT_VALID   4
`define TRX_STAT_ALIGNED 5

`define TRX_RPT_LIMIT    3'd5
`define TRX_UNST_LIMIT   4'd8
`define TRX_LAST_BIT     3'd7
`define TRX_LAST_BYTE    4'd15

`define TRX_RESP_OKAY    2'b00
`define TRX_RESP_SLVERR  2'b10

`endif

// ===== pkg/trace_rx_pkg.sv
package trace_rx_pkg;

  typedef enum logic [0:0] {
    ALIGN_HUNT    = 1'b0,
    ALIGN_COLLECT = 1'b1
  } align_state_t;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_ADDR = 2'b01,
    RD_DATA = 2'b10,
    RD_RESP = 2'b11
  } rd_state_t;

  typedef logic [15:0][7:0] trace_id_t;

  typedef struct packed {
    logic [3:0]   ctrl;
    logic         change;
    logic         idle;
    logic         unstable;
    logic         mismatch;
    logic         acc_valid;
    logic         aligned;
    align_state_t align_st;
    logic [2:0]   bit_cnt;
    logic [6:0]   shift;
    logic [3:0]   byte_idx;
    trace_id_t    stage;
    logic [2:0]   rpt_cnt;
    logic [3:0]   unst_cnt;
    logic         aw_held;
    logic [7:0]   awaddr;
    logic         w_held;
    logic [31:0]  wdata;
    logic [3:0]   wstrb;
    logic         awready;
    logic         wready;
    logic         bvalid;
    logic [1:0]   bresp;
    rd_state_t    rd_st;
    logic [7:0]   araddr;
    logic         arready;
    logic         rvalid;
    logic [31:0]  rdata;
    logic [1:0]   rresp;
  } rx_state_t;

  typedef struct packed {
    logic [47:0][7:0] mem;
    logic [7:0]       rd_data;
  } store_state_t;

endpackage : trace_rx_pkg

// ===== design/trace_store.sv
`timescale 1ns/1ps
`include "trace_rx_consts.svh"

// Identifier storage: current, accepted and expected identifiers.
module trace_store
  import trace_rx_pkg::*;
(
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             cur_we,
  input  wire trace_id_t        cur_data,
  input  wire logic             acc_we,
  input  wire trace_id_t        acc_data,
  input  wire logic             exp_we,
  input  wire logic [3:0]       exp_idx,
  input  wire logic [7:0]       exp_byte,
  input  wire logic [5:0]       rd_addr,
  output logic      [7:0]       rd_data,
  output trace_id_t             cur_id,
  output trace_id_t             acc_id,
  output trace_id_t             exp_id
);

  store_state_t s;
  store_state_t next_s;

  always_comb begin
    next_s = s;
    for (int i = 0; i < 16; i++) begin
      if (cur_we) begin
        next_s.mem[i] = cur_data[i];
      end
      if (acc_we) begin
        next_s.mem[i + 16] = acc_data[i];
      end
    end
    if (exp_we) begin
      next_s.mem[{2'b10, exp_idx}] = exp_byte;
    end
    next_s.rd_data = (rd_addr < 6'd48) ? s.mem[rd_addr] : 8'h00;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign rd_data = s.rd_data;
  assign cur_id  = s.mem[15:0];
  assign acc_id  = s.mem[31:16];
  assign exp_id  = s.mem[47:32];

endmodule : trace_store

// ===== verification/trace_src_model.sv
`timescale 1ns/1ps
module trace_src (
  input  wire logic aclk,
  output logic      trace_serial_bit,
  output logic      trace_bit_valid,
  output logic      line_los,
  output logic      line_lof,
  output logic      line_ais
);
  initial begin
    trace_serial_bit = 1'b0;
    trace_bit_valid  = 1'b0;
    {line_ais, line_lof, line_los} = 3'h0;
  end

  // Between bits the line shows the inverse of the last bit.
  task automatic send_byte(input logic [7:0] b, input int gap);
    for (int i = 7; i >= 0; i--) begin
      @(posedge aclk);
      trace_serial_bit <= b[i];
      trace_bit_valid  <= 1'b1;
      repeat (gap) begin
        @(posedge aclk);
        trace_bit_valid  <= 1'b0;
        trace_serial_bit <= ~b[i];
      end
    end
    @(posedge aclk);
    trace_bit_valid  <= 1'b0;
    trace_serial_bit <= ~b[0];
  endtask : send_byte

  task automatic set_defect(input logic [2:0] d);
    @(posedge aclk);
    {line_ais, line_lof, line_los} <= d;
  endtask : set_defect
endmodule : trace_src

// ===== verification/trail_trace_receive_path_props.sv
`timescale 1ns/1ps
module trace_rx_props (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        trace_change,
  input wire logic        trace_idle,
  input wire logic        trace_unstable,
  input wire logic        trace_mismatch
);
  logic seen;

  always_ff @(posedge aclk) begin
    if (!aresetn) seen <= 1'b0;
    else if (trace_change) seen <= 1'b1;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence

  a_wr_answer:
    assert property (s_wr_take |=> !s_axi_awready && !s_axi_bvalid
      ##1 s_axi_bvalid) else $error("write answer late");
  a_rd_answer:
    assert property (s_rd_take |=> (!s_axi_arready && !s_axi_rvalid)[*2]
      ##1 s_axi_rvalid) else $error("read answer late");
  a_b_hold:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
      && $stable(s_axi_bresp)) else $error("write answer dropped");
  a_r_hold:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata)) else $error("read answer dropped");
  a_refused_zero:
    assert property (s_axi_rvalid && s_axi_rresp == 2'b10 |->
      s_axi_rdata == 32'h0) else $error("refused read data");
  a_idle_unstable:
    assert property (!(trace_idle && trace_unstable))
      else $error("idle with unstable");
  a_change_clear:
    assert property ($fell(trace_change) |-> $rose(s_axi_bvalid))
      else $error("change flag lost");
  a_no_early_mism:
    assert property (!seen |-> !trace_mismatch)
      else $error("mismatch before update");
endmodule : trace_rx_props

bind trail_trace_receive_path trace_rx_props chk_u (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata, .s_axi_rresp, .trace_change, .trace_idle,
  .trace_unstable, .trace_mismatch
);

// ===== verification/tb.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin \
  bad_count++; $display("MISMATCH %s exp %h got %h", n, e, a); end end
module tb;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        trace_serial_bit, trace_bit_valid;
  logic        line_los, line_lof, line_ais;
  logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rresp_q;
  logic [31:0] s_axi_rdata, rd_q;
  logic        trace_change, trace_idle, trace_unstable, trace_mismatch;
  logic [7:0]  id [16];
  logic [31:0] seed = 32'h7077;
  int          bad_count = 0;
  int          checks_done = 0;
  logic [15:0][7:0] m_cur = '0, m_acc = '0, m_exp = '0;
  logic [3:0]  ctrl_q = 4'h0;
  int          m_rpt = 0, m_unst = 0;
  logic        m_chg = 1'b0, m_idle = 1'b0, m_unsf = 1'b0, m_accv = 1'b0;

  always #2.5 aclk = ~aclk;

  trace_src src_u (.aclk, .trace_serial_bit, .trace_bit_valid,
    .line_los, .line_lof, .line_ais);

  trail_trace_receive_path dut_u (.aclk, .aresetn, .trace_serial_bit,
    .trace_bit_valid, .line_los, .line_lof, .line_ais, .s_axi_awaddr,
    .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .trace_change, .trace_idle,
    .trace_unstable, .trace_mismatch);

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // Mismatch as the model sees it, with the alignment bit left out.
  function automatic logic m_mism();
    logic [127:0] msk;
    msk = ctrl_q[3] ? {16{8'hfe}} : {16{8'h7f}};
    return ctrl_q[2] && ctrl_q[1] && m_accv && ((m_acc ^ m_exp) & msk) != 0;
  endfunction : m_mism

  // Reference model of the identifier checks, fed once per identifier.
  task automatic mdl();
    logic [15:0][7:0] v;
    logic [127:0]     msk;
    msk = ctrl_q[3] ? {16{8'hfe}} : {16{8'h7f}};
    foreach (id[i]) begin
      for (int b = 0; b < 8; b++) begin
        v[i][b] = ctrl_q[3] ? id[i][7 - b] : id[i][b];
      end
    end
    m_rpt  = (v == m_cur) ? ((m_rpt < 5) ? m_rpt + 1 : 5) : 1;
    m_unst = (v != m_cur && v != m_acc) ?
             ((m_unst < 8) ? m_unst + 1 : 8) : 0;
    if (m_rpt == 5 && (v & msk) != 0 && v != m_acc) begin
      m_acc  = v;
      m_accv = 1'b1;
      m_chg  = 1'b1;
    end
    if (m_rpt == 5) begin
      m_idle = (v & msk) == 0;
      m_unsf = 1'b0;
    end
    if (m_unst == 8) begin
      m_unsf = 1'b1;
      m_idle = 1'b0;
    end
    m_cur = v;
  endtask : mdl

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid && !s_axi_awready
               || s_axi_wvalid && !s_axi_wready);
    while (!s_axi_bvalid) @(posedge aclk);
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
    if (a == 8'h00) ctrl_q = d[3:0];
    if (a == 8'h04 && d[0]) m_chg = 1'b0;
    if (a >= 8'hc0) m_exp[a[5:2]] = d[7:0];
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge aclk);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    rd_q = s_axi_rdata;
    rresp_q = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic chk_st(input logic [3:0] m, input logic [3:0] e);
    logic [3:0] pin;
    logic [3:0] mdl_st;
    rd(8'h04);
    pin = {trace_mismatch, trace_unstable, trace_idle, trace_change};
    mdl_st = {m_mism(), m_unsf, m_idle, m_chg};
    `CHK("status", e, rd_q[3:0] & m)
    `CHK("status model", mdl_st & m, rd_q[3:0] & m)
    `CHK("status pins", e, pin & m)
  endtask : chk_st

  task automatic chk_mem(input int base, input bit rev);
    logic [7:0] e;
    for (int i = 0; i < 16; i++) begin
      rd(8'(8'h40 + 4 * (base + i)));
      for (int b = 0; b < 8; b++) e[b] = rev ? id[i][7 - b] : id[i][b];
      `CHK("stored byte", {24'h0, e}, rd_q)
    end
  endtask : chk_mem

  task automatic mk_id();
    foreach (id[i]) id[i] = 8'(rnd()) & 8'h7f;
    id[0] |= 8'h80;
    id[1] |= 8'h01;
  endtask : mk_id

  task automatic send_id(input int reps, input logic [7:0] x);
    repeat (reps) begin
      foreach (id[i]) src_u.send_byte(id[i] ^ x, int'(rnd() & 32'h1));
      mdl();
    end
  endtask : send_id

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test

  initial begin
    #200000;
    bad_count++;
    stop_test();
  end

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h00);
    `CHK("ctrl", 32'h0, rd_q)
    chk_st(4'hf, 4'h0);
    `CHK("valid aligned", 2'b00, rd_q[5:4])
    rd(8'h08);
    `CHK("unmapped", 2'b10, rresp_q)
    wr(8'h00, 32'h6);
    repeat (3) src_u.send_byte(8'(rnd()) & 8'h7f, 0);
    mk_id();
    send_id(5, 8'h00);
    chk_st(4'hf, 4'h9);
    `CHK("valid aligned", 2'b11, rd_q[5:4])
    chk_mem(0, 1'b0);
    chk_mem(16, 1'b0);
    for (int i = 0; i < 16; i++)
      wr(8'(8'hc0 + 4 * i), {24'h0, id[i] ^ 8'h80});
    chk_st(4'h8, 4'h0);
    wr(8'hcc, {24'h0, id[3] ^ 8'h01});
    chk_st(4'h8, 4'h8);
    wr(8'h00, 32'h4);
    chk_st(4'h8, 4'h0);
    wr(8'h04, 32'h1);
    chk_st(4'h1, 4'h0);
    wr(8'h00, 32'ha);
    mk_id();
    send_id(5, 8'h00);
    chk_st(4'h1, 4'h1);
    chk_mem(0, 1'b1);
    wr(8'h00, 32'h3);
    send_id(5, 8'hff);
    chk_mem(0, 1'b0);
    wr(8'h00, 32'h0);
    foreach (id[i]) id[i] = 8'hff;
    for (int d = 0; d < 3; d++) begin
      src_u.set_defect(3'(1 << d));
      repeat (16) src_u.send_byte(8'(rnd()), 1);
      mdl();
      chk_mem(0, 1'b0);
    end
    src_u.set_defect(3'h0);
    foreach (id[i]) id[i] = 8'h00;
    send_id(5, 8'h00);
    chk_st(4'h6, 4'h2);
    repeat (8) begin
      mk_id();
      send_id(1, 8'h00);
    end
    chk_st(4'h6, 4'h4);
    foreach (id[i]) id[i] = 8'h00;
    send_id(5, 8'h00);
    chk_st(4'h6, 4'h2);
    stop_test();
  end
endmodule : tb
